/* File: pewc_host.sv */
// Host controller driving the pins of a byte-wide parallel EEPROM
`timescale 1ns/1ps
module pewc_host #(
   parameter int unsigned BLC_CYC       = pewc_pkg::BLC_CYC,
   parameter int unsigned WC_CYC        = pewc_pkg::WC_CYC,
   parameter int unsigned POR_CYC       = pewc_pkg::POR_CYC,
   parameter logic [38:0] LOCK_ON_ADDR  = pewc_pkg::LOCK_ON_ADDR,
   parameter logic [23:0] LOCK_ON_DATA  = pewc_pkg::LOCK_ON_DATA,
   parameter logic [38:0] LOCK_OFF_ADDR = pewc_pkg::LOCK_OFF_ADDR,
   parameter logic [23:0] LOCK_OFF_DATA = pewc_pkg::LOCK_OFF_DATA
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   // Supply monitor
   input  wire logic        SUPPLY_GOOD,
   // Command port
   input  wire logic        CMD_VALID,
   output logic             CMD_READY,
   input  wire logic [1:0]  CMD_OP,
   input  wire logic [12:0] CMD_ADDR,
   input  wire logic [6:0]  CMD_LEN,
   input  wire logic        CMD_ID,
   input  wire logic        LOCK_USE,
   // Page data load
   input  wire logic        BUF_WE,
   input  wire logic [5:0]  BUF_IDX,
   input  wire logic [7:0]  BUF_DATA,
   // Answer
   output logic             RSP_VALID,
   output logic [7:0]       RSP_DATA,
   output logic             RSP_ERR,
   // Memory pins
   output logic             EE_CS_N,
   output logic             EE_OE_N,
   output logic             EE_WE_N,
   output logic [12:0]      EE_ADDR,
   output logic             EE_ID_HV,
   input  wire logic [7:0]  EE_DQ_I,
   output logic [7:0]       EE_DQ_O,
   output logic             EE_DQ_OE
);

   localparam logic [20:0] WC_LIM = 21'(WC_CYC);

   // Pick entry i of a packed command table
   function automatic logic [12:0] pick_a(input logic [38:0] v,
                                          input logic [5:0] i);
      return v[13*i +: 13];
   endfunction
   function automatic logic [7:0] pick_d(input logic [23:0] v,
                                         input logic [5:0] i);
      return v[8*i +: 8];
   endfunction
   // Short timer load values
   function automatic logic [20:0] tload(input int unsigned c);
      return 21'(c - 1);
   endfunction

   pewc_pkg::pewc_state_t st_ff, nxt_st;
   pewc_pkg::pewc_op_t    op_ff, nxt_op;
   logic [20:0] tmr_ff, nxt_tmr, wc_ff, nxt_wc, por_ff, nxt_por;
   logic [12:0] base_ff, nxt_base, addr_ff, nxt_addr;
   logic [6:0]  len_ff, nxt_len;
   logic [5:0]  idx_ff, nxt_idx;
   logic [7:0]  dq_ff, nxt_dq, rsp_d_ff, nxt_rsp_d;
   logic        cmd_ph_ff, nxt_cmd_ph, poll_ff, nxt_poll;
   logic        prev_ok_ff, nxt_prev_ok, prev6_ff, nxt_prev6;
   logic        id_ff, nxt_id, rdy_ff, nxt_rdy, rv_ff, nxt_rv;
   logic        err_ff, nxt_err, cs_ff, nxt_cs, oe_ff, nxt_oe;
   logic        we_ff, nxt_we, dqoe_ff, nxt_dqoe, por_ok_ff, nxt_por_ok;
   logic [7:0]  buf_q, cur_d;
   logic [12:0] cur_a;
   logic [5:0]  lo_a;
   logic        pair_ok_ff, nxt_pair_ok;

   pewc_pbuf #(
      .DEPTH (pewc_pkg::PAGE_BYTES),
      .AW    (pewc_pkg::IDX_W),
      .DW    (pewc_pkg::DATA_W)
   ) u_pbuf (
      .clk     (CLK),
      .wr_en   (BUF_WE),
      .wr_idx  (BUF_IDX),
      .wr_data (BUF_DATA),
      .rd_idx  (idx_ff),
      .rd_data (buf_q)
   );

   // Power-on lockout; a supply dip restarts the wait
   always_comb begin
      nxt_por    = por_ff;
      nxt_por_ok = por_ok_ff;
      if (!SUPPLY_GOOD) begin
         nxt_por    = '0;
         nxt_por_ok = 1'b0;
      end else if (por_ff == 21'(POR_CYC)) begin
         nxt_por_ok = 1'b1;
      end else begin
         nxt_por = por_ff + 21'h000001;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         por_ff    <= '0;
         por_ok_ff <= 1'b0;
      end else begin
         por_ff    <= nxt_por;
         por_ok_ff <= nxt_por_ok;
      end
   end

   // Byte of the current step: command table or page buffer
   always_comb begin
      lo_a = 6'(base_ff[5:0] + idx_ff);
      if (cmd_ph_ff) begin
         cur_a = (op_ff == pewc_pkg::OP_LOCK_OFF) ?
                 pick_a(LOCK_OFF_ADDR, idx_ff) : pick_a(LOCK_ON_ADDR, idx_ff);
         cur_d = (op_ff == pewc_pkg::OP_LOCK_OFF) ?
                 pick_d(LOCK_OFF_DATA, idx_ff) : pick_d(LOCK_ON_DATA, idx_ff);
      end else begin
         // Page bits never move inside one load
         cur_a = {id_ff ? pewc_pkg::ID_PAGE : base_ff[12:6], lo_a};
         cur_d = buf_q;
      end
   end

   // Sequencer: strobed byte loads, then toggle-bit polling
   always_comb begin
      nxt_st = st_ff;   nxt_op = op_ff;     nxt_tmr = tmr_ff;
      nxt_wc = wc_ff;   nxt_base = base_ff; nxt_addr = addr_ff;
      nxt_len = len_ff; nxt_idx = idx_ff;   nxt_dq = dq_ff;
      nxt_cmd_ph = cmd_ph_ff; nxt_poll = poll_ff; nxt_prev_ok = prev_ok_ff;
      nxt_prev6 = prev6_ff;   nxt_id = id_ff;     nxt_rdy = 1'b0;
      nxt_rv = 1'b0;    nxt_rsp_d = rsp_d_ff; nxt_err = err_ff;
      nxt_cs = 1'b1;    nxt_oe = 1'b1;      nxt_we = 1'b1;
      nxt_dqoe = 1'b0;
      if (poll_ff && wc_ff != WC_LIM) begin
         nxt_wc = wc_ff + 21'h000001;
      end
      if (st_ff != pewc_pkg::ST_IDLE && tmr_ff != '0) begin
         nxt_tmr = tmr_ff - 21'h000001;
      end
      unique case (st_ff)
         pewc_pkg::ST_IDLE: begin
            nxt_rdy = por_ok_ff;
            nxt_id  = 1'b0;
            if (CMD_VALID && rdy_ff) begin
               nxt_rdy = 1'b0;
               nxt_op = pewc_pkg::pewc_op_t'(CMD_OP);
               nxt_base = CMD_ADDR;
               nxt_len = (CMD_LEN == '0) ? 7'h01 : CMD_LEN;
               nxt_idx = '0;
               nxt_poll = 1'b0;
               nxt_prev_ok = 1'b0;
               nxt_wc = '0;
               nxt_err = 1'b0;
               nxt_id = CMD_ID & CMD_OP[1] == 1'b0;
               // Prefix writes when lock is in use
               nxt_cmd_ph = CMD_OP[1] | (CMD_OP[0] & LOCK_USE);
               if (CMD_OP == pewc_pkg::OP_READ) begin
                  nxt_addr = CMD_ID ? {pewc_pkg::ID_PAGE, CMD_ADDR[5:0]} :
                             CMD_ADDR;
                  nxt_st = pewc_pkg::ST_RLOW;
                  nxt_tmr = tload(pewc_pkg::ACC_CYC);
               end else begin
                  nxt_st = pewc_pkg::ST_SETUP;
                  nxt_tmr = tload(pewc_pkg::AS_CYC);
               end
            end
         end
         pewc_pkg::ST_SETUP: begin
            // Output enable stays high while loading
            nxt_cs = 1'b0;
            nxt_addr = cur_a;
            nxt_dq = cur_d;
            nxt_dqoe = 1'b1;
            if (tmr_ff == '0) begin
               nxt_st = pewc_pkg::ST_WLOW;
               nxt_we = 1'b0;
               nxt_tmr = tload(pewc_pkg::WP_CYC);
            end
         end
         pewc_pkg::ST_WLOW: begin
            // Address and data held still across the pulse
            nxt_cs = 1'b0;
            nxt_dqoe = 1'b1;
            nxt_we = 1'b0;
            if (tmr_ff == '0) begin
               nxt_we = 1'b1;
               nxt_st = pewc_pkg::ST_WHIGH;
               nxt_tmr = tload(pewc_pkg::WPH_CYC);
            end
         end
         pewc_pkg::ST_WHIGH: begin
            // Hold covers address and data hold after the rising strobe
            nxt_cs = 1'b0;
            nxt_dqoe = 1'b1;
            if (tmr_ff == '0) begin
               nxt_cs = 1'b1;
               nxt_dqoe = 1'b0;
               nxt_idx = idx_ff + 6'h01;
               nxt_st = pewc_pkg::ST_SETUP;
               nxt_tmr = tload(pewc_pkg::AS_CYC);
               // Bytes follow back to back, far inside the window
               if (cmd_ph_ff && idx_ff == 6'(pewc_pkg::CMD_BYTES - 1)) begin
                  nxt_cmd_ph = 1'b0;
                  nxt_idx = '0;
                  if (op_ff != pewc_pkg::OP_WRITE) begin
                     nxt_poll = 1'b1;
                  end
               end else if (!cmd_ph_ff && 7'(idx_ff) == len_ff - 7'h01) begin
                  nxt_poll = 1'b1;
               end
               if (nxt_poll) begin
                  // Poll the last byte written
                  nxt_st = pewc_pkg::ST_REND;
                  nxt_tmr = tload(pewc_pkg::DF_CYC);
               end
            end
         end
         pewc_pkg::ST_RLOW: begin
            nxt_cs = 1'b0;
            nxt_oe = 1'b0;
            if (tmr_ff == '0) begin
               nxt_cs = 1'b1;
               nxt_oe = 1'b1;
               nxt_rsp_d = EE_DQ_I;
               nxt_prev6 = EE_DQ_I[pewc_pkg::TOGGLE_BIT];
               nxt_prev_ok = 1'b1;
               nxt_st = pewc_pkg::ST_REND;
               nxt_tmr = tload(pewc_pkg::DF_CYC);
            end
         end
         pewc_pkg::ST_REND: begin
            // Wait for the device to float before any further drive
            if (tmr_ff == '0) begin
               if (!poll_ff) begin
                  nxt_rv = 1'b1;
                  nxt_st = pewc_pkg::ST_IDLE;
               end else if (pair_ok_ff) begin
                  nxt_poll = 1'b0;
                  nxt_rv = 1'b1;
                  nxt_st = pewc_pkg::ST_IDLE;
               end else if (wc_ff == WC_LIM) begin
                  nxt_poll = 1'b0;
                  nxt_err = 1'b1;
                  nxt_rv = 1'b1;
                  nxt_st = pewc_pkg::ST_IDLE;
               end else begin
                  nxt_st = pewc_pkg::ST_RLOW;
                  nxt_tmr = tload(pewc_pkg::ACC_CYC);
               end
            end
         end
         default: begin
            nxt_st = pewc_pkg::ST_IDLE;
         end
      endcase
   end

   // Two equal toggle bits in a row mark the end of programming;
   // the first read of a command has no partner, so it never ends it
   always_comb begin
      nxt_pair_ok = pair_ok_ff;
      if (st_ff == pewc_pkg::ST_IDLE) begin
         nxt_pair_ok = 1'b0;
      end else if (st_ff == pewc_pkg::ST_RLOW && tmr_ff == '0) begin
         nxt_pair_ok = prev_ok_ff &&
                       (EE_DQ_I[pewc_pkg::TOGGLE_BIT] == prev6_ff);
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pair_ok_ff <= 1'b0;
      end else begin
         pair_ok_ff <= nxt_pair_ok;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_ff <= pewc_pkg::ST_IDLE;  op_ff <= pewc_pkg::OP_READ;
         tmr_ff <= '0;  wc_ff <= '0;  base_ff <= '0;  addr_ff <= '0;
         len_ff <= 7'h01;  idx_ff <= '0;  dq_ff <= '0;  cmd_ph_ff <= 1'b0;
         poll_ff <= 1'b0;  prev_ok_ff <= 1'b0;  prev6_ff <= 1'b0;
         id_ff <= 1'b0;  rdy_ff <= 1'b0;  rv_ff <= 1'b0;  rsp_d_ff <= '0;
         err_ff <= 1'b0;  cs_ff <= 1'b1;  oe_ff <= 1'b1;  we_ff <= 1'b1;
         dqoe_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;  op_ff <= nxt_op;
         tmr_ff <= nxt_tmr;  wc_ff <= nxt_wc;  base_ff <= nxt_base;
         addr_ff <= nxt_addr;  len_ff <= nxt_len;  idx_ff <= nxt_idx;
         dq_ff <= nxt_dq;  cmd_ph_ff <= nxt_cmd_ph;  poll_ff <= nxt_poll;
         prev_ok_ff <= nxt_prev_ok;  prev6_ff <= nxt_prev6;
         id_ff <= nxt_id;  rdy_ff <= nxt_rdy;  rv_ff <= nxt_rv;
         rsp_d_ff <= nxt_rsp_d;  err_ff <= nxt_err;  cs_ff <= nxt_cs;
         oe_ff <= nxt_oe;  we_ff <= nxt_we;  dqoe_ff <= nxt_dqoe;
      end
   end

   // Pins and answers straight from flip-flops
   assign CMD_READY = rdy_ff;
   assign RSP_VALID = rv_ff;
   assign RSP_DATA  = rsp_d_ff;
   assign RSP_ERR   = err_ff;
   assign EE_CS_N   = cs_ff;
   assign EE_OE_N   = oe_ff;
   assign EE_WE_N   = we_ff;
   assign EE_ADDR   = addr_ff;
   assign EE_ID_HV  = id_ff;
   assign EE_DQ_O   = dq_ff;
   assign EE_DQ_OE  = dqoe_ff;

   // Cycles since the last rising strobe of one load
   logic [20:0] gap_ff, nxt_gap;
   always_comb begin
      nxt_gap = '0;
      if (st_ff != pewc_pkg::ST_IDLE && !poll_ff && we_ff) begin
         nxt_gap = gap_ff + 21'h000001;
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gap_ff <= '0;
      end else begin
         gap_ff <= nxt_gap;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_we_fall;
      $fell(EE_WE_N);
   endsequence
   sequence s_we_hold;
      !EE_WE_N [*8] ##1 !EE_WE_N;
   endsequence

   a_we_pulse_width: assert property (s_we_fall |-> s_we_hold)
      else $error("write strobe pulse too short");
   a_oe_high_write: assert property (
      !EE_WE_N |-> EE_OE_N && !EE_CS_N)
      else $error("strobe low with output enable low or deselected");
   a_addr_stable: assert property (
      !EE_WE_N && !$past(EE_WE_N) |-> $stable(EE_ADDR))
      else $error("address moved during write strobe");
   a_data_stable: assert property (
      $rose(EE_WE_N) |-> $stable(EE_DQ_O) && EE_DQ_OE)
      else $error("data not held at strobe rise");
   a_page_const: assert property (
      s_we_fall ##0 !cmd_ph_ff |->
      EE_ADDR[12:6] == (id_ff ? pewc_pkg::ID_PAGE : base_ff[12:6]))
      else $error("page address changed inside a load");
   a_load_window: assert property (gap_ff < 21'(BLC_CYC))
      else $error("byte load window exceeded");
   a_por_block: assert property (!por_ok_ff |-> EE_WE_N)
      else $error("write attempted during power-on lockout");
   a_no_contend: assert property (
      !EE_OE_N |-> !EE_DQ_OE && EE_WE_N)
      else $error("host drives data while device may drive");
   a_prefix_first: assert property (
      $fell(EE_WE_N) && cmd_ph_ff &&
      idx_ff == 6'h00 |-> EE_ADDR == ((op_ff == pewc_pkg::OP_LOCK_OFF) ?
      LOCK_OFF_ADDR[12:0] : LOCK_ON_ADDR[12:0]))
      else $error("command prefix does not start with first pair");
   a_poll_reads: assert property (
      $rose(poll_ff) |-> ##[1:20] !EE_OE_N)
      else $error("no status read after load");

endmodule // pewc_host

/* File: pewc_pkg.sv */
// Constants, timing counts and types for the parallel EEPROM host controller
package pewc_pkg;

   // Geometry of the memory behind the pins
   localparam int unsigned ADDR_W     = 13;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned PAGE_BYTES = 64;
   localparam int unsigned IDX_W      = 6;
   localparam int unsigned LEN_W      = 7;
   localparam int unsigned PAGE_LSB   = 6;
   localparam logic [6:0]  ID_PAGE    = 7'h7f;   // Area 1FC0H..1FFFH
   localparam int unsigned POLL_BIT   = 7;
   localparam int unsigned TOGGLE_BIT = 6;
   localparam int unsigned CMD_BYTES  = 3;

   // Clock and printed times
   localparam int unsigned CLK_MHZ    = 100;
   localparam int unsigned T_AS_NS    = 20;      // Setup before strobe
   localparam int unsigned T_WP_NS    = 100;     // Write pulse width, min
   localparam int unsigned T_WPH_NS   = 50;      // Pulse high and holds, min
   localparam int unsigned T_ACC_NS   = 150;     // Read access, max
   localparam int unsigned T_DF_NS    = 50;      // Output float, max
   localparam int unsigned T_BLC_US   = 150;     // Byte load window, max
   localparam int unsigned T_WC_MS    = 10;      // Write cycle, max
   localparam int unsigned T_POR_MS   = 5;       // Power-on lockout

   // Least times round up, the load window rounds down
   function automatic int unsigned ns_up(input int unsigned ns);
      return (ns * CLK_MHZ + 999) / 1000;
   endfunction

   localparam int unsigned AS_CYC  = ns_up(T_AS_NS);
   localparam int unsigned WP_CYC  = ns_up(T_WP_NS);
   localparam int unsigned WPH_CYC = ns_up(T_WPH_NS);
   localparam int unsigned ACC_CYC = ns_up(T_ACC_NS);
   localparam int unsigned DF_CYC  = ns_up(T_DF_NS);
   localparam int unsigned BLC_CYC = T_BLC_US * CLK_MHZ;
   localparam int unsigned WC_CYC  = T_WC_MS * 1000 * CLK_MHZ;
   localparam int unsigned POR_CYC = T_POR_MS * 1000 * CLK_MHZ;
   localparam int unsigned TMR_W   = 21;

   // Lock command sequences, three address/data pairs, first pair low
   localparam logic [38:0] LOCK_ON_ADDR  = {13'h0003, 13'h0002, 13'h0001};
   localparam logic [23:0] LOCK_ON_DATA  = {8'h33, 8'h22, 8'h11};
   localparam logic [38:0] LOCK_OFF_ADDR = {13'h0003, 13'h0002, 13'h0001};
   localparam logic [23:0] LOCK_OFF_DATA = {8'h66, 8'h55, 8'h44};

   // User commands
   typedef enum logic [1:0] {
      OP_READ     = 2'h0,
      OP_WRITE    = 2'h1,
      OP_LOCK_ON  = 2'h2,
      OP_LOCK_OFF = 2'h3
   } pewc_op_t;

   // Bus sequencer, Gray codes along write then poll
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SETUP = 3'h1,
      ST_WLOW  = 3'h3,
      ST_WHIGH = 3'h2,
      ST_RLOW  = 3'h6,
      ST_REND  = 3'h7
   } pewc_state_t;

endpackage

/* File: pewc_pbuf.sv */
// Page data buffer: 64 bytes, one write port, registered read
`timescale 1ns/1ps
module pewc_pbuf #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned AW    = 6,
   parameter int unsigned DW    = 8
) (
   // Clock
   input  wire logic          clk,
   // Write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_idx,
   input  wire logic [DW-1:0] wr_data,
   // Read side
   input  wire logic [AW-1:0] rd_idx,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] mem [DEPTH];

   // Storage has no reset; the host fills it before each page
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
   end

endmodule // pewc_pbuf

/* File: pewc_host_fix.sv */
// Holds no logic; the host controller lives in pewc_host.sv

/* File: pewc_ee_model.sv */
// Behavioural model of the byte-wide EEPROM behind the host pins
`timescale 1ns/1ps
module pewc_ee_model #(
   parameter int BLC  = 200,  // Load window in cycles
   parameter int PROG = 300,  // Programming time, inside the poll limit
   parameter int LAT  = 10    // Read data shows late, like a slow part
) (
   // Sampling clock and strobes
   input  wire logic        clk,
   input  wire logic        cs_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [12:0] addr,
   input  wire logic        id_hv,
   // Host side of the data pins, and the resolved wire
   input  wire logic [7:0]  h_dq,
   input  wire logic        h_oe,
   output logic      [7:0]  bus
);
   logic [7:0]  mem [8192];
   logic [7:0]  idm [64];
   logic [7:0]  pb [64];
   logic [63:0] msk = '0;
   logic [12:0] al;
   logic [7:0]  ld = 8'h00;
   logic [7:0]  pv = 8'h00;
   logic [6:0]  pg;
   logic        wq = 1'b0, rq = 1'b0, busy = 1'b0, ldg = 1'b0;
   logic        lck = 1'b0, tg = 1'b0, pid = 1'b0, on, off;
   int          bn, pn, rn = 0, nb = 0, onn = 0, ofn = 0;
   wire         wa = !cs_n && !we_n && oe_n;
   wire         ra = !cs_n && !oe_n && we_n;
   // Array comes up erased; no reset pin, so lock survives host resets
   initial foreach (mem[i]) mem[i] = 8'hff;
   initial foreach (idm[i]) idm[i] = 8'hff;
   // Byte latching, load window, programming and lock state
   always @(posedge clk) begin
      if (wa && !wq) al = addr;
      if (!wa && wq && !busy) begin
         on = onn == nb && nb < 3 && al == pewc_pkg::LOCK_ON_ADDR[13*nb+:13]
              && h_dq == pewc_pkg::LOCK_ON_DATA[8*nb+:8];
         off = ofn == nb && nb < 3 && al == pewc_pkg::LOCK_OFF_ADDR[13*nb+:13]
               && h_dq == pewc_pkg::LOCK_OFF_DATA[8*nb+:8];
         onn = onn + int'(on);
         ofn = ofn + int'(off);
         if (!on && !off) begin
            pb[al[5:0]] = h_dq;
            msk[al[5:0]] = 1'b1;
            pg = al[12:6];
            pid = id_hv;
         end
         nb++;
         ld = h_dq;
         ldg = 1'b1;
         bn = 0;
      end else if (ldg) begin
         bn++;
         // A read ends the load at once; the host polls right after loading
         if (bn >= BLC || ra) begin
            if (lck && onn < 3 && ofn < 3) msk = '0;
            lck = ofn < 3 && (lck || onn == 3);
            ldg = 1'b0;
            busy = 1'b1;
            pn = 0;
         end
      end else if (busy) begin
         pn++;
         if (pn >= PROG) begin
            for (int i = 0; i < 64; i++) begin
               if (msk[i] && pid && pg == 7'h7f) idm[i] = pb[i];
               else if (msk[i]) mem[{pg, 6'(i)}] = pb[i];
            end
            {busy, msk} = '0;
            {nb, onn, ofn} = '0;
         end
      end
      if (!ra && rq && busy) tg = ~tg;
      rn = ra ? rn + 1 : 0;
      wq = wa;
      rq = ra;
      pv = bus;
   end
   // Released wire shows last cycle's value inverted, so a stale byte returns every other cycle
   always @* begin
      if (ra && rn >= LAT) begin
         if (busy) bus = {~ld[7], tg, ld[5:0]};
         else if (id_hv && addr[12:6] == 7'h7f) bus = idm[addr[5:0]];
         else bus = mem[addr];
      end else if (h_oe) bus = h_dq;
      else bus = ~pv;
   end
endmodule  // pewc_ee_model

/* File: tb_top.sv */
// Self-checking bench: host controller against the EEPROM model
`timescale 1ns/1ps
module tb_top;
   localparam int POR = 20;
   logic        clk, arst_n, sg, cv, cid, luse, bwe;
   logic        crdy, rv, rerr, cs_n, oe_n, we_n, idhv, dqoe;
   logic [1:0]  op;
   logic [12:0] ca, ea;
   logic [6:0]  cl;
   logic [5:0]  bi;
   logic [7:0]  bd, rd, dqo, dqi;
   logic [7:0]  sh [8192];
   logic [7:0]  ish [64];
   logic [31:0] seed = 32'h695e;
   int          err_total = 0, num_checks = 0, cyc = 0, bad = 0;
   pewc_host #(.BLC_CYC(200), .WC_CYC(2000), .POR_CYC(POR)) pewc_host_inst (
      .CLK(clk), .ARST_N(arst_n), .SUPPLY_GOOD(sg), .CMD_VALID(cv),
      .CMD_READY(crdy), .CMD_OP(op), .CMD_ADDR(ca), .CMD_LEN(cl),
      .CMD_ID(cid), .LOCK_USE(luse), .BUF_WE(bwe), .BUF_IDX(bi),
      .BUF_DATA(bd), .RSP_VALID(rv), .RSP_DATA(rd), .RSP_ERR(rerr),
      .EE_CS_N(cs_n), .EE_OE_N(oe_n), .EE_WE_N(we_n), .EE_ADDR(ea),
      .EE_ID_HV(idhv), .EE_DQ_I(dqi), .EE_DQ_O(dqo), .EE_DQ_OE(dqoe));
   pewc_ee_model pewc_ee_model_inst (
      .clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(ea),
      .id_hv(idhv), .h_dq(dqo), .h_oe(dqoe), .bus(dqi));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard; pins are watched off the edge so registers have settled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if ((dqoe === 1'b1 || we_n === 1'b0) && oe_n !== 1'b1) bad <= bad + 1;
      if (cyc == 90000) begin
         err_total++;
         end_sim();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Supply drops with the reset, so the lockout restarts each time
   task automatic do_reset();
      int k;
      k = 0;
      {arst_n, sg} <= 2'b00;
      repeat (3) @(posedge clk);
      {arst_n, sg} <= 2'b11;
      while (crdy !== 1'b1 && k < 500) begin
         @(negedge clk);
         k++;
      end
      check(8'(k > POR), 8'h1);
   endtask
   // One command, held until taken, then wait for its answer
   task automatic cmd(input logic [1:0] o, input logic [12:0] a,
                      input logic [6:0] n, input logic id);
      @(posedge clk);
      {cv, op, ca, cl, cid} <= {1'b1, o, a, n, id};
      @(negedge clk);
      while (crdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      cv <= 1'b0;
      @(negedge clk);
      while (rv !== 1'b1) @(negedge clk);
      check({7'h0, rerr}, 8'h0);
   endtask
   // Random bytes into the buffer, then write; shadow updated if kept
   task automatic wr(input logic [12:0] a, input int n, input logic id,
                     input logic keep);
      logic [12:0] p;
      for (int i = 0; i < n; i++) begin
         seed = xs(seed);
         @(posedge clk);
         {bwe, bi, bd} <= {1'b1, 6'(i), seed[7:0]};
         p = {a[12:6], 6'(a[5:0] + i)};
         if (keep && id) ish[p[5:0]] = seed[7:0];
         else if (keep) sh[p] = seed[7:0];
      end
      @(posedge clk);
      bwe <= 1'b0;
      cmd(2'h1, a, 7'(n), id);
      check(rd, id ? ish[p[5:0]] : sh[p]);
   endtask
   task automatic rdc(input logic [12:0] a, input logic id);
      cmd(2'h0, a, 7'h1, id);
      check(rd, id ? ish[a[5:0]] : sh[a]);
   endtask
   initial begin
      int n;
      logic [12:0] a;
      {arst_n, sg, cv, cid, luse, bwe, op, ca, cl, bi, bd} = '0;
      foreach (sh[i]) sh[i] = 8'hff;
      foreach (ish[i]) ish[i] = 8'hff;
      do_reset();
      rdc(13'h0abc, 1'b0);
      $display("test reset done");
      // Single byte first, then a full page that wraps, then random sizes
      for (int t = 0; t < 8; t++) begin
         seed = xs(seed);
         n = (t == 0) ? 1 : (t == 1) ? 64 : 1 + int'(seed[13:8]);
         a = seed[28:16];
         wr(a, n, 1'b0, 1'b1);
         rdc(a, 1'b0);
         rdc({a[12:6], 6'(a[5:0] + n - 1)}, 1'b0);
         rdc({a[12:6], 6'(a[5:0] + n)}, 1'b0);
      end
      wr(13'h1fc5, 3, 1'b1, 1'b1);
      rdc(13'h1fc6, 1'b1);
      rdc(13'h1fc6, 1'b0);
      $display("test pages done");
      cmd(2'h2, 13'h0000, 7'h1, 1'b0);
      wr(13'h0105, 2, 1'b0, 1'b0);
      rdc(13'h0105, 1'b0);
      do_reset();
      wr(13'h0106, 1, 1'b0, 1'b0);
      rdc(13'h0106, 1'b0);
      @(posedge clk);
      luse <= 1'b1;
      wr(13'h0001, 2, 1'b0, 1'b1);
      rdc(13'h0001, 1'b0);
      rdc(13'h0003, 1'b0);
      @(posedge clk);
      luse <= 1'b0;
      cmd(2'h3, 13'h0000, 7'h1, 1'b0);
      wr(13'h0040, 4, 1'b0, 1'b1);
      rdc(13'h0043, 1'b0);
      $display("test lock done");
      check(8'(bad), 8'h0);
      end_sim();
   end
endmodule  // tb_top
